// >>> sr_logic_pkg.sv
package sr_logic_pkg;

  // Timebase: one step of every delay is a tenth of a second
  localparam int unsigned CLK_HZ      = 100_000_000;
  localparam int unsigned TICK_MS     = 100;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

  // Field widths
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned SEL_W  = 4;
  localparam int unsigned SRC_N  = 15;
  localparam int unsigned DLY_W  = 19;
  localparam int unsigned CNT_W  = 14;
  localparam int unsigned TOD_W  = 20;
  localparam int unsigned DATE_W = 16;
  localparam int unsigned FF_N   = 4;
  localparam int unsigned CTR_N  = 2;

  // Limits: 9:59:59.9 in tenths, and the top count
  localparam logic [DLY_W-1:0] DLY_MAX = 19'h57E3F;
  localparam logic [CNT_W-1:0] CNT_MAX = 14'h2710;

  // Priority encodings
  typedef enum logic [1:0] {
    PRIO_RESET = 2'h0,
    PRIO_SET   = 2'h1,
    PRIO_EDGE  = 2'h2
  } prio_e;

  // Word offsets
  localparam logic [ADDR_W-1:0] OFS_FF_MODE  = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_FF_SEL   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_FF_SDLY  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_FF_RDLY  = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_FF_TMR   = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_CTR_SEL  = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_CTR_TRIP = 8'h16;
  localparam logic [ADDR_W-1:0] OFS_CTR_CNT  = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_WIN_TON  = 8'h1A;
  localparam logic [ADDR_W-1:0] OFS_WIN_TOFF = 8'h1B;
  localparam logic [ADDR_W-1:0] OFS_WIN_DON  = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_WIN_DOFF = 8'h1D;
  localparam logic [ADDR_W-1:0] OFS_WIN_DAYS = 8'h1E;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h1F;

  // Values after reset
  localparam logic [7:0]        RST_FF_MODES = 8'h90;
  localparam logic [DLY_W-1:0]  RST_DLY      = 19'h00000;
  localparam logic [CNT_W-1:0]  RST_TRIP     = 14'h0000;
  localparam logic [TOD_W-1:0]  RST_TOD      = 20'h00000;
  localparam logic [DATE_W-1:0] RST_DATE     = 16'h0000;
  localparam logic [6:0]        RST_DAYS     = 7'h7F;

endpackage

// >>> ff_link_if.sv
interface ff_link_if;
  logic [1:0]                     mode;
  logic [sr_logic_pkg::DLY_W-1:0] set_dly;
  logic [sr_logic_pkg::DLY_W-1:0] res_dly;
  logic                           set_lvl;
  logic                           res_lvl;
  logic                           tick;
  logic                           q;
  logic [sr_logic_pkg::DLY_W-1:0] tmr;

  modport unit (
    input  mode,
    input  set_dly,
    input  res_dly,
    input  set_lvl,
    input  res_lvl,
    input  tick,
    output q,
    output tmr
  );

  modport ctrl (
    output mode,
    output set_dly,
    output res_dly,
    output set_lvl,
    output res_lvl,
    output tick,
    input  q,
    input  tmr
  );
endinterface

// >>> sr_ff_unit.sv
module sr_ff_unit (
  // Clock and reset
  input  wire logic mclk_i,
  input  wire logic arst_n_i,
  // Configuration and levels
  ff_link_if.unit   lk
);

  logic [sr_logic_pkg::DLY_W-1:0] set_cnt;
  logic [sr_logic_pkg::DLY_W-1:0] res_cnt;
  logic                           set_dl;
  logic                           res_dl;
  logic                           set_q;
  logic                           res_q;
  logic                           q;
  wire                            set_ok;
  wire                            res_ok;
  wire                            set_rise;
  wire                            res_rise;
  wire                            both;
  wire                            next_q;

  // Delayed levels: input must stand for the full delay
  assign set_ok = lk.set_lvl && (set_cnt >= lk.set_dly);
  assign res_ok = lk.res_lvl && (res_cnt >= lk.res_dly);

  // Delay timers restart whenever their input drops
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      set_cnt <= sr_logic_pkg::RST_DLY;
      res_cnt <= sr_logic_pkg::RST_DLY;
    end
    else
    begin
      set_cnt <= !lk.set_lvl ? sr_logic_pkg::RST_DLY :
                 (lk.tick && !set_ok) ? set_cnt + 19'h00001 : set_cnt;
      res_cnt <= !lk.res_lvl ? sr_logic_pkg::RST_DLY :
                 (lk.tick && !res_ok) ? res_cnt + 19'h00001 : res_cnt;
    end
  end

  // Edges against last cycle's copy of the delayed levels
  assign set_rise = set_dl && !set_q;
  assign res_rise = res_dl && !res_q;
  assign both     = set_dl && res_dl;

  // Only an edge changes the output; levels alone hold it
  assign next_q =
    !(set_rise || res_rise) ? q :
    !both ? set_dl :
    (lk.mode == sr_logic_pkg::PRIO_SET) ? 1'b1 :
    (lk.mode == sr_logic_pkg::PRIO_EDGE) ?
      ((set_rise && res_rise) ? q : set_rise) :
    1'b0;

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      set_dl <= 1'b0;
      res_dl <= 1'b0;
      set_q  <= 1'b0;
      res_q  <= 1'b0;
      q      <= 1'b0;
    end
    else
    begin
      set_dl <= set_ok;
      res_dl <= res_ok;
      set_q  <= set_dl;
      res_q  <= res_dl;
      q      <= next_q;
    end
  end

  // Visible timer: the pending set delay, else the reset delay
  assign lk.q   = q;
  assign lk.tmr = lk.set_lvl && !set_ok ? set_cnt : res_cnt;

endmodule

// >>> sr_logic_top.sv
// The address-and-strobe port and the register offsets were left to the implementer.
module sr_logic_top #(
  parameter int unsigned TICK_CYCLES = sr_logic_pkg::TICK_CYCLES,
  parameter int unsigned SRC_N       = sr_logic_pkg::SRC_N
) (
  // Clock and reset
  input  wire logic                              mclk_i,
  input  wire logic                              arst_n_i,
  // Register port
  input  wire logic [sr_logic_pkg::ADDR_W-1:0]   addr_i,
  input  wire logic [sr_logic_pkg::DATA_W-1:0]   wdata_i,
  input  wire logic                              wr_i,
  input  wire logic                              rd_i,
  output logic      [sr_logic_pkg::DATA_W-1:0]   rdata_o,
  // Selectable signal sources
  input  wire logic [SRC_N-1:0]                  src_i,
  // Calendar from the real-time clock
  input  wire logic [sr_logic_pkg::TOD_W-1:0]    rtc_time_i,
  input  wire logic [sr_logic_pkg::DATE_W-1:0]   rtc_date_i,
  input  wire logic [2:0]                        rtc_weekday_i,
  // Function outputs
  output logic      [sr_logic_pkg::FF_N-1:0]     ff_out_o,
  output logic                                   counter_one_trip_out_o,
  output logic                                   counter_two_trip_out_o,
  output logic                                   window_out_o
);

  localparam int unsigned FF_N  = sr_logic_pkg::FF_N;
  localparam int unsigned CTR_N = sr_logic_pkg::CTR_N;
  localparam int unsigned DLY_W = sr_logic_pkg::DLY_W;
  localparam int unsigned CNT_W = sr_logic_pkg::CNT_W;
  localparam int unsigned TOD_W = sr_logic_pkg::TOD_W;
  localparam int unsigned DT_W  = sr_logic_pkg::DATE_W;
  localparam int unsigned DW    = sr_logic_pkg::DATA_W;

  // Pick one source; code zero is the off selection
  function automatic logic pick_src(input logic [SRC_N-1:0] src,
                                    input logic [3:0]       sel);
    logic r;
    r = 1'b0;
    if (sel != 4'h0 && 32'(sel) <= SRC_N)
    begin
      r = src[sel - 4'h1];
    end
    return r;
  endfunction

  // Clamp a written delay to the largest legal figure
  function automatic logic [DLY_W-1:0] clamp_dly(input logic [DW-1:0] v);
    return (v > 32'(sr_logic_pkg::DLY_MAX)) ?
           sr_logic_pkg::DLY_MAX : v[DLY_W-1:0];
  endfunction

  // Clamp a written trip value to the count range
  function automatic logic [CNT_W-1:0] clamp_cnt(input logic [DW-1:0] v);
    return (v > 32'(sr_logic_pkg::CNT_MAX)) ?
           sr_logic_pkg::CNT_MAX : v[CNT_W-1:0];
  endfunction

  // Software-visible settings
  logic [1:0]       ff_mode   [FF_N];
  logic [7:0]       ff_sel    [FF_N];
  logic [DLY_W-1:0] ff_sdly   [FF_N];
  logic [DLY_W-1:0] ff_rdly   [FF_N];
  logic [7:0]       ctr_sel   [CTR_N];
  logic [CNT_W-1:0] ctr_trip  [CTR_N];
  logic [TOD_W-1:0] win_ton;
  logic [TOD_W-1:0] win_toff;
  logic [DT_W-1:0]  win_don;
  logic [DT_W-1:0]  win_doff;
  logic [6:0]       win_days;

  // Function state
  logic [CNT_W-1:0] ctr_cnt   [CTR_N];
  logic [CTR_N-1:0] trig_q;
  logic [CTR_N-1:0] trip;
  logic             win_on;
  logic [31:0]      tick_cnt;
  logic             tick;

  wire  [FF_N-1:0]  ff_q;
  wire  [DLY_W-1:0] ff_tmr    [FF_N];
  wire  [CTR_N-1:0] trig_lvl;
  wire  [CTR_N-1:0] rst_lvl;
  wire  [CTR_N-1:0] trig_rise;
  wire  [CTR_N-1:0] next_trip;
  wire  [DW-1:0]    next_rdata;
  wire  [DW-1:0]    status;
  wire              on_hit;
  wire              off_hit;
  wire              day_ok;

  // Tenth-of-second timebase for all delays
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      tick_cnt <= 32'h00000000;
      tick     <= 1'b0;
    end
    else
    begin
      tick     <= (tick_cnt == TICK_CYCLES - 1);
      tick_cnt <= (tick_cnt == TICK_CYCLES - 1) ? 32'h00000000 :
                  tick_cnt + 32'h00000001;
    end
  end

  // Register writes; defaults give per-unit priorities
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      for (int i = 0; i < FF_N; i++)
      begin
        ff_mode[i] <= sr_logic_pkg::RST_FF_MODES[2*i +: 2];
        ff_sel[i]  <= 8'h00;
        ff_sdly[i] <= sr_logic_pkg::RST_DLY;
        ff_rdly[i] <= sr_logic_pkg::RST_DLY;
      end
      for (int c = 0; c < CTR_N; c++)
      begin
        ctr_sel[c]  <= 8'h00;
        ctr_trip[c] <= sr_logic_pkg::RST_TRIP;
      end
      win_ton  <= sr_logic_pkg::RST_TOD;
      win_toff <= sr_logic_pkg::RST_TOD;
      win_don  <= sr_logic_pkg::RST_DATE;
      win_doff <= sr_logic_pkg::RST_DATE;
      win_days <= sr_logic_pkg::RST_DAYS;
    end
    else if (wr_i)
    begin
      for (int i = 0; i < FF_N; i++)
      begin
        if (addr_i == sr_logic_pkg::OFS_FF_MODE + 8'(i))
        begin
          ff_mode[i] <= wdata_i[1:0];
        end
        if (addr_i == sr_logic_pkg::OFS_FF_SEL + 8'(i))
        begin
          ff_sel[i] <= wdata_i[7:0];
        end
        if (addr_i == sr_logic_pkg::OFS_FF_SDLY + 8'(i))
        begin
          ff_sdly[i] <= clamp_dly(wdata_i);
        end
        if (addr_i == sr_logic_pkg::OFS_FF_RDLY + 8'(i))
        begin
          ff_rdly[i] <= clamp_dly(wdata_i);
        end
      end
      for (int c = 0; c < CTR_N; c++)
      begin
        if (addr_i == sr_logic_pkg::OFS_CTR_SEL + 8'(c))
        begin
          ctr_sel[c] <= wdata_i[7:0];
        end
        if (addr_i == sr_logic_pkg::OFS_CTR_TRIP + 8'(c))
        begin
          ctr_trip[c] <= clamp_cnt(wdata_i);
        end
      end
      if (addr_i == sr_logic_pkg::OFS_WIN_TON)
      begin
        win_ton <= wdata_i[TOD_W-1:0];
      end
      if (addr_i == sr_logic_pkg::OFS_WIN_TOFF)
      begin
        win_toff <= wdata_i[TOD_W-1:0];
      end
      if (addr_i == sr_logic_pkg::OFS_WIN_DON)
      begin
        win_don <= wdata_i[DT_W-1:0];
      end
      if (addr_i == sr_logic_pkg::OFS_WIN_DOFF)
      begin
        win_doff <= wdata_i[DT_W-1:0];
      end
      if (addr_i == sr_logic_pkg::OFS_WIN_DAYS)
      begin
        win_days <= wdata_i[6:0];
      end
    end
  end

  // Four identical flip-flop units
  for (genvar g = 0; g < FF_N; g++)
  begin : g_ff
    ff_link_if lk ();

    assign lk.mode    = ff_mode[g];
    assign lk.set_dly = ff_sdly[g];
    assign lk.res_dly = ff_rdly[g];
    assign lk.set_lvl = pick_src(src_i, ff_sel[g][3:0]);
    assign lk.res_lvl = pick_src(src_i, ff_sel[g][7:4]);
    assign lk.tick    = tick;
    assign ff_q[g]    = lk.q;
    assign ff_tmr[g]  = lk.tmr;

    sr_ff_unit u_ff (
      .mclk_i   (mclk_i),
      .arst_n_i (arst_n_i),
      .lk       (lk.unit)
    );
  end

  // Counter sources and edges; fast sources may lose pulses
  for (genvar c = 0; c < CTR_N; c++)
  begin : g_ctr_sel
    assign trig_lvl[c]  = pick_src(src_i, ctr_sel[c][3:0]);
    assign rst_lvl[c]   = pick_src(src_i, ctr_sel[c][7:4]);
    assign trig_rise[c] = trig_lvl[c] && !trig_q[c];
    // Zero trip keeps the output high regardless of count
    assign next_trip[c] = (ctr_trip[c] == 14'h0000) ||
                          (ctr_cnt[c] == ctr_trip[c]);
  end

  // Both counters share one process, reset over any edge
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      for (int c = 0; c < CTR_N; c++)
      begin
        ctr_cnt[c] <= 14'h0000;
      end
      trig_q <= '0;
      trip   <= '0;
    end
    else
    begin
      trig_q <= trig_lvl;
      trip   <= next_trip;
      for (int c = 0; c < CTR_N; c++)
      begin
        if (rst_lvl[c])
        begin
          ctr_cnt[c] <= 14'h0000;
        end
        else if (trig_rise[c] && ctr_cnt[c] != sr_logic_pkg::CNT_MAX)
        begin
          ctr_cnt[c] <= ctr_cnt[c] + 14'h0001;
        end
      end
    end
  end

  // Calendar window; a backwards off date never switches off
  assign on_hit  = (rtc_date_i == win_don) && (rtc_time_i == win_ton);
  assign off_hit = (rtc_date_i == win_doff) && (rtc_time_i == win_toff) &&
                   !(win_doff < win_don);
  assign day_ok  = (rtc_weekday_i <= 3'h6) && win_days[rtc_weekday_i];

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      win_on       <= 1'b0;
      window_out_o <= 1'b0;
    end
    else
    begin
      win_on       <= on_hit ? 1'b1 : (off_hit ? 1'b0 : win_on);
      window_out_o <= win_on && day_ok;
    end
  end

  // Read decode; unmapped words read zero
  assign status = {25'h0000000, window_out_o, trip, ff_q};

  function automatic logic [DW-1:0] read_word(input logic [7:0] a);
    logic [DW-1:0] r;
    r = 32'h00000000;
    for (int i = 0; i < FF_N; i++)
    begin
      if (a == sr_logic_pkg::OFS_FF_MODE + 8'(i)) r = 32'(ff_mode[i]);
      if (a == sr_logic_pkg::OFS_FF_SEL + 8'(i))  r = 32'(ff_sel[i]);
      if (a == sr_logic_pkg::OFS_FF_SDLY + 8'(i)) r = 32'(ff_sdly[i]);
      if (a == sr_logic_pkg::OFS_FF_RDLY + 8'(i)) r = 32'(ff_rdly[i]);
      if (a == sr_logic_pkg::OFS_FF_TMR + 8'(i))  r = 32'(ff_tmr[i]);
    end
    for (int c = 0; c < CTR_N; c++)
    begin
      if (a == sr_logic_pkg::OFS_CTR_SEL + 8'(c))  r = 32'(ctr_sel[c]);
      if (a == sr_logic_pkg::OFS_CTR_TRIP + 8'(c)) r = 32'(ctr_trip[c]);
      if (a == sr_logic_pkg::OFS_CTR_CNT + 8'(c))  r = 32'(ctr_cnt[c]);
    end
    if (a == sr_logic_pkg::OFS_WIN_TON)  r = 32'(win_ton);
    if (a == sr_logic_pkg::OFS_WIN_TOFF) r = 32'(win_toff);
    if (a == sr_logic_pkg::OFS_WIN_DON)  r = 32'(win_don);
    if (a == sr_logic_pkg::OFS_WIN_DOFF) r = 32'(win_doff);
    if (a == sr_logic_pkg::OFS_WIN_DAYS) r = 32'(win_days);
    if (a == sr_logic_pkg::OFS_STATUS)   r = status;
    return r;
  endfunction

  assign next_rdata = rd_i ? read_word(addr_i) : 32'h00000000;

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rdata_o                <= 32'h00000000;
      ff_out_o               <= '0;
      counter_one_trip_out_o <= 1'b0;
      counter_two_trip_out_o <= 1'b0;
    end
    else
    begin
      rdata_o                <= next_rdata;
      ff_out_o               <= ff_q;
      counter_one_trip_out_o <= next_trip[0];
      counter_two_trip_out_o <= next_trip[1];
    end
  end

endmodule

// >>> sr_logic_sva.sv
module sr_logic_sva #(
  parameter int unsigned TICK_CYCLES = sr_logic_pkg::TICK_CYCLES,
  parameter int unsigned SRC_N       = sr_logic_pkg::SRC_N
) (
  // Clock and reset
  input  wire logic                              mclk_i,
  input  wire logic                              arst_n_i,
  // Register port
  input  wire logic [sr_logic_pkg::ADDR_W-1:0]   addr_i,
  input  wire logic [sr_logic_pkg::DATA_W-1:0]   wdata_i,
  input  wire logic                              wr_i,
  input  wire logic                              rd_i,
  input  wire logic [sr_logic_pkg::DATA_W-1:0]   rdata_o,
  // Sources and calendar
  input  wire logic [SRC_N-1:0]                  src_i,
  input  wire logic [sr_logic_pkg::TOD_W-1:0]    rtc_time_i,
  input  wire logic [sr_logic_pkg::DATE_W-1:0]   rtc_date_i,
  input  wire logic [2:0]                        rtc_weekday_i,
  // Function outputs
  input  wire logic [sr_logic_pkg::FF_N-1:0]     ff_out_o,
  input  wire logic                              counter_one_trip_out_o,
  input  wire logic                              counter_two_trip_out_o,
  input  wire logic                              window_out_o
);
  logic [1:0] up;
  logic       dly_on;
  logic       trip1_zero;
  logic       trip2_zero;

  // Shadowed settings; delays make outputs move without input change
  wire rdy      = (up == 2'h3);
  wire wr_dly   = wr_i && (addr_i[7:3] == 5'h01);
  wire wr_trip1 = wr_i && (addr_i == 8'h16);
  wire wr_trip2 = wr_i && (addr_i == 8'h17);
  wire wd_zero  = (wdata_i == 32'h0);

  // Settle counter and shadows
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      up         <= 2'h0;
      dly_on     <= 1'b0;
      trip1_zero <= 1'b1;
      trip2_zero <= 1'b1;
    end
    else
    begin
      up         <= rdy ? up : up + 2'h1;
      dly_on     <= dly_on || (wr_dly && !wd_zero);
      trip1_zero <= wr_trip1 ? wd_zero : trip1_zero;
      trip2_zero <= wr_trip2 ? wd_zero : trip2_zero;
    end
  end

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!arst_n_i);

  sequence src_quiet;
    $stable(src_i) && !wr_i;
  endsequence

  sequence ff_quiet;
    $stable(src_i) && !wr_i && !dly_on;
  endsequence

  sequence rtc_quiet;
    $stable(rtc_time_i) && $stable(rtc_date_i) && $stable(rtc_weekday_i)
      && !wr_i;
  endsequence

  AST_RD_IDLE:
    assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data not zero outside read slot");
  AST_RD_UNMAPPED:
    assert property ($past(rd_i) && ($past(addr_i) > 8'h1F)
      |-> rdata_o == 32'h0)
    else $error("unmapped read not zero");
  AST_TRIP1_ZERO:
    assert property (rdy && trip1_zero && $past(trip1_zero, 2)
      |-> counter_one_trip_out_o)
    else $error("trip one low with zero trip value");
  AST_TRIP2_ZERO:
    assert property (rdy && trip2_zero && $past(trip2_zero, 2)
      |-> counter_two_trip_out_o)
    else $error("trip two low with zero trip value");
  AST_FF_STATIC:
    assert property (ff_quiet [*6] |=> $stable(ff_out_o))
    else $error("flip-flop moved on static inputs");
  AST_TRIP_STATIC:
    assert property (rdy ##0 src_quiet [*6] |=> $stable(counter_one_trip_out_o)
      && $stable(counter_two_trip_out_o))
    else $error("trip moved without trigger edge");
  AST_WIN_STATIC:
    assert property (rtc_quiet [*4] |=> $stable(window_out_o))
    else $error("window moved on static calendar");
  AST_WIN_NODAY:
    assert property ((rtc_weekday_i == 3'h7) [*4] |-> !window_out_o)
    else $error("window high with no weekday");
  AST_AFTER_RESET:
    assert property (!rdy |-> ff_out_o == 4'h0)
    else $error("flip-flop set right after reset");
endmodule

// >>> tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // Short tick keeps delay runs brief
  localparam int unsigned TICKS = 4;

  logic        mclk_i;
  logic        arst_n_i;
  logic [7:0]  addr_i;
  logic [31:0] wdata_i;
  logic        wr_i;
  logic        rd_i;
  logic [14:0] src_i;
  logic [19:0] rtc_time_i;
  logic [15:0] rtc_date_i;
  logic [2:0]  rtc_weekday_i;
  logic [31:0] rdata_o;
  logic [3:0]  ff_out_o;
  logic        counter_one_trip_out_o;
  logic        counter_two_trip_out_o;
  logic        window_out_o;
  int          failures;
  int          checked;
  int          trip;
  int          k;
  int          n;
  logic [31:0] got;
  logic [3:0]  exp_q;
  logic [1:0]  prev;
  logic [1:0]  nxt;
  logic [1:0]  modes [4];
  logic [1:0]  corner [7] = '{2'h3, 2'h0, 2'h1, 2'h3, 2'h2, 2'h3, 2'h0};

  sr_logic_top #(.TICK_CYCLES(TICKS), .SRC_N(15)) dut (
    .mclk_i                 (mclk_i),
    .arst_n_i               (arst_n_i),
    .addr_i                 (addr_i),
    .wdata_i                (wdata_i),
    .wr_i                   (wr_i),
    .rd_i                   (rd_i),
    .rdata_o                (rdata_o),
    .src_i                  (src_i),
    .rtc_time_i             (rtc_time_i),
    .rtc_date_i             (rtc_date_i),
    .rtc_weekday_i          (rtc_weekday_i),
    .ff_out_o               (ff_out_o),
    .counter_one_trip_out_o (counter_one_trip_out_o),
    .counter_two_trip_out_o (counter_two_trip_out_o),
    .window_out_o           (window_out_o)
  );

  // 100 MHz clock
  initial
  begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  task automatic test_done;
    if (failures == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic cyc(input int c);
    repeat (c) @(posedge mclk_i);
    #1;
  endtask

  // Bus cycles; strobes last one clock
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge mclk_i);
    wr_i    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge mclk_i);
    rd_i   <= 1'b0;
    #1;
    got = rdata_o;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(got, e);
  endtask

  task automatic pulse(input int b, input int c);
    repeat (c)
    begin
      @(posedge mclk_i);
      src_i[b] <= 1'b1;
      @(posedge mclk_i);
      src_i[b] <= 1'b0;
    end
  endtask

  task automatic win(input logic [15:0] d, input logic [19:0] t,
                     input logic [2:0] w, input logic e);
    @(posedge mclk_i);
    rtc_date_i    <= d;
    rtc_time_i    <= t;
    rtc_weekday_i <= w;
    cyc(4);
    chk(window_out_o, e);
  endtask

  // Expected flip-flop output from old and new set/reset levels
  function automatic logic ff_next(input logic [1:0] m, input logic q,
                                   input logic [1:0] p, input logic [1:0] v);
    logic se;
    logic re;
    se = v[0] && !p[0];
    re = v[1] && !p[1];
    if (!(se || re))
      return q;
    if (m == 2'h2)
      return (se && re) ? q : se;
    if (m == 2'h1)
      return v[0];
    return v[0] && !v[1];
  endfunction

  // Main sequence
  initial
  begin
    failures = 0;
    checked = 0;
    arst_n_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 32'h0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    src_i = 15'h0;
    rtc_time_i = 20'h0;
    rtc_date_i = 16'hFFFF;
    rtc_weekday_i = 3'h0;
    void'($urandom(89));
    repeat (4) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    for (int u = 0; u < 4; u++)
    begin
      rdc(8'(u), (u < 2) ? 32'h0 : 32'(u - 1));
      rdc(8'(8 + u), 32'h0);
      rdc(8'(12 + u), 32'h0);
    end
    rdc(8'h16, 32'h0);
    rdc(8'h19, 32'h0);
    rdc(8'h1E, 32'h7F);
    rdc(8'h40, 32'h0);
    chk({counter_two_trip_out_o, counter_one_trip_out_o}, 2'h3);
    // All four units share the same two sources, modes rotated
    for (int u = 0; u < 4; u++)
      wr(8'(4 + u), 32'h21);
    exp_q = 4'h0;
    prev = 2'h0;
    for (int r = 0; r < 2; r++)
    begin
      for (int u = 0; u < 4; u++)
      begin
        modes[u] = 2'((u + r) % 4);
        wr(8'(u), 32'(modes[u]));
      end
      for (int s = 0; s < 27; s++)
      begin
        nxt = (s < 7) ? corner[s] : 2'($urandom);
        @(posedge mclk_i);
        src_i[1:0] <= nxt;
        for (int u = 0; u < 4; u++)
          exp_q[u] = ff_next(modes[u], exp_q[u], prev, nxt);
        prev = nxt;
        cyc(5);
        chk(ff_out_o, exp_q);
      end
    end
    // Counters: exact trips, random counts, reset held over edges
    wr(8'h14, 32'h43);
    wr(8'h15, 32'h65);
    for (int c = 0; c < 2; c++)
      for (int r = 0; r < 3; r++)
      begin
        trip = 1 + $urandom % 20;
        k = (r == 0) ? trip : $urandom % 25;
        wr(8'(22 + c), 32'(trip));
        pulse(2 + 2 * c, k);
        cyc(3);
        rdc(8'(24 + c), 32'(k));
        chk(c ? counter_two_trip_out_o : counter_one_trip_out_o,
            32'(k == trip));
        @(posedge mclk_i);
        src_i[3 + 2 * c] <= 1'b1;
        pulse(2 + 2 * c, 2);
        rdc(8'(24 + c), 32'h0);
        @(posedge mclk_i);
        src_i[3 + 2 * c] <= 1'b0;
      end
    wr(8'h16, 32'h4E20);
    rdc(8'h16, 32'h2710);
    pulse(2, 10003);
    cyc(3);
    wr(8'h18, 32'h5);
    rdc(8'h18, 32'h2710);
    chk(counter_one_trip_out_o, 1'b1);
    rd(8'h1F);
    chk(got & 32'hFFFFFFF0, 32'h10);
    // Clock window
    wr(8'h1A, 32'h5);
    wr(8'h1B, 32'h9);
    wr(8'h1C, 32'h2);
    wr(8'h1D, 32'h2);
    win(16'h2, 20'h5, 3'h0, 1'b1);
    win(16'h2, 20'h9, 3'h0, 1'b0);
    win(16'h2, 20'h5, 3'h3, 1'b1);
    wr(8'h1D, 32'h1);
    win(16'h1, 20'h9, 3'h3, 1'b1);
    win(16'h1, 20'h9, 3'h7, 1'b0);
    wr(8'h1E, 32'h77);
    win(16'h1, 20'h9, 3'h3, 1'b0);
    wr(8'h1E, 32'h7F);
    win(16'h1, 20'h9, 3'h3, 1'b1);
    // Set delay of six ticks on unit one
    wr(8'h00, 32'h0);
    // Random run may leave set high, which would hide the delayed edge
    @(posedge mclk_i);
    src_i[1:0] <= 2'h0;
    pulse(1, 1);
    wr(8'h08, 32'h6);
    @(posedge mclk_i);
    src_i[0] <= 1'b1;
    cyc(8);
    rd(8'h10);
    chk(got != 32'h0 && got < 32'h6, 1'b1);
    chk(ff_out_o[0], 1'b0);
    n = 10;
    while (ff_out_o[0] !== 1'b1 && n < 60)
    begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    if (n >= 60)
    begin
      failures++;
      test_done;
    end
    chk(n >= 20 && n <= 32, 1'b1);
    rdc(8'h10, 32'h0);
    wr(8'h0C, 32'h7FFFF);
    rdc(8'h0C, 32'h57E3F);
    // Count off its trip, then a zero trip must force the output high
    wr(8'h17, 32'h1);
    pulse(4, 3);
    cyc(3);
    chk(counter_two_trip_out_o, 1'b0);
    wr(8'h17, 32'h0);
    cyc(3);
    chk(counter_two_trip_out_o, 1'b1);
    test_done;
  end
endmodule

bind sr_logic_top sr_logic_sva #(
  .TICK_CYCLES (TICK_CYCLES),
  .SRC_N       (SRC_N)
) sva (
  .mclk_i                 (mclk_i),
  .arst_n_i               (arst_n_i),
  .addr_i                 (addr_i),
  .wdata_i                (wdata_i),
  .wr_i                   (wr_i),
  .rd_i                   (rd_i),
  .rdata_o                (rdata_o),
  .src_i                  (src_i),
  .rtc_time_i             (rtc_time_i),
  .rtc_date_i             (rtc_date_i),
  .rtc_weekday_i          (rtc_weekday_i),
  .ff_out_o               (ff_out_o),
  .counter_one_trip_out_o (counter_one_trip_out_o),
  .counter_two_trip_out_o (counter_two_trip_out_o),
  .window_out_o           (window_out_o)
);
